/* port_cfg.svh */
// Constants for the graphics-port handshake block.
// Assumes mclk at 250 MHz; included by its bare name.
`ifndef PORT_CFG_SVH
`define PORT_CFG_SVH

`define CLK_MHZ 250
// Master gives up waiting for a device select after this time
`define ABORT_NS 24
`define ABORT_CYC ((`ABORT_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_STAGES 2

// Bus commands on the command/byte-enable lines
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_READ_MULT 4'hc
`define CMD_MEM_READ_LINE 4'he
`define CMD_MEM_WRITE_INV 4'hf

// Status-bus codes
`define ST_LP_READ 3'h0
`define ST_IDLE_CODE 3'h7

`endif

/* port_pkg.sv */
// Types shared by the graphics-port handshake block.
// Assumes nothing beyond the constants header.
package port_pkg;
   typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} mst_state_t;
   typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} tgt_state_t;
   typedef logic [2:0] port_status_t;
endpackage : port_pkg

/* arb_if.sv */
// Carrier between the port core and its arbiter.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface arb_if;
   logic req;
   logic bus_free;
   logic st_lp_read;
   port_pkg::port_status_t st_code;
   logic gnt;
   port_pkg::port_status_t st;
   modport core (output req, output bus_free, output st_lp_read, output st_code,
                 input gnt, input st);
   modport arb (input req, input bus_free, input st_lp_read, input st_code,
                output gnt, output st);
endinterface : arb_if

/* port_arbiter.sv */
// Grant arbiter for the single external graphics initiator.
// Assumes a synchronised request and a bus-free term from the core.
`timescale 1ns/1ps
`include "port_cfg.svh"
module port_arbiter (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Core side
   arb_if.arb a
);
   logic gnt_r;
   logic gnt_nxt;
   port_pkg::port_status_t st_r;
   port_pkg::port_status_t st_nxt;
   wire logic grant_now = a.req && a.bus_free && !gnt_r;

   assign gnt_nxt = grant_now ? 1'b1 : (gnt_r && a.req);
   assign st_nxt = !grant_now ? st_r :
                   a.st_lp_read ? `ST_LP_READ : a.st_code;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gnt_r <= 1'b0;
         st_r <= `ST_IDLE_CODE;
      end else begin
         gnt_r <= gnt_nxt;
         st_r <= st_nxt;
      end
   end

   assign a.gnt = gnt_r;
   assign a.st = st_r;

   a_grant_needs_req: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(gnt_r) |-> $past(a.req)) else $error("grant without request");
   a_grant_when_free: assert property (@(posedge mclk) disable iff (!rst_n)
      a.req && a.bus_free && !gnt_r |=> gnt_r) else $error("grant late");
   a_status_with_grant: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(gnt_r) |-> st_r == ($past(a.st_lp_read) ? `ST_LP_READ : $past(a.st_code)))
      else $error("status not loaded with grant");
   a_lp_read_code: assert property (@(posedge mclk) disable iff (!rst_n)
      grant_now && a.st_lp_read |=> st_r == 3'h0) else $error("low priority code wrong");
endmodule : port_arbiter

/* agp_pci_port.sv */
// Graphics-port control handshake: arbiter, master and target sides.
// Assumes pins arrive asynchronously and pass two flops before use.
// Overview of operation
// - Assert device select on own memory hits
// - Target claims memory commands only
// - Master samples device select for claim
// - Select, frame, stop, parity unused in AGP
// - Master asserts frame to start transaction
// - Target samples frame of external initiator
// - Grant only answers a request
// - Drive status bus with grant
// - Reset negates grant
// - Grant once request seen and bus free
// - Master asserts initiator ready when able
// - Sample initiator ready during AGP transactions
// - Generate even parity, never check it
// - Forward system error when enabled, PCI only
// - Target asserts stop to force disconnect
// - Master ends transfer on sampled stop
// - Target asserts target ready when able
// - Master samples target ready for pacing
// - Word moves only when both readies asserted
// - Address valid in first frame clock
// - Status 000 returns low-priority read data
`timescale 1ns/1ps
`include "port_cfg.svh"
module agp_pci_port #(
   parameter logic [31:0] REGION_BASE = 32'h0000_0000,
   parameter logic [31:0] REGION_MASK = 32'hf000_0000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Mode and configuration
   input wire logic pci_style_mode,
   input wire logic serr_fwd_en,
   // Address/data and command pins
   input wire logic [31:0] port_ad_in,
   output logic [31:0] port_ad_out,
   output logic port_ad_oe,
   input wire logic [3:0] port_cmd_byte_enable_n_in,
   output logic [3:0] port_cmd_byte_enable_n_out,
   output logic port_cmd_byte_enable_n_oe,
   // Handshake pins
   input wire logic port_cycle_frame_n_in,
   output logic port_cycle_frame_n_out,
   output logic port_cycle_frame_n_oe,
   input wire logic port_initiator_ready_n_in,
   output logic port_initiator_ready_n_out,
   output logic port_initiator_ready_n_oe,
   input wire logic port_target_ready_n_in,
   output logic port_target_ready_n_out,
   output logic port_target_ready_n_oe,
   input wire logic port_device_select_n_in,
   output logic port_device_select_n_out,
   output logic port_device_select_n_oe,
   input wire logic port_stop_n_in,
   output logic port_stop_n_out,
   output logic port_stop_n_oe,
   input wire logic port_parity_in,
   output logic port_parity_out,
   output logic port_parity_oe,
   // Arbitration pins
   input wire logic port_request_n,
   output logic port_grant_n,
   output port_pkg::port_status_t port_status,
   // System error
   input wire logic port_system_error_in_n,
   output logic pci_system_error_n,
   // Processor-side master requests
   input wire logic cpu_req,
   input wire logic cpu_write,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   input wire logic [3:0] cpu_be_n,
   output logic cpu_busy,
   output logic cpu_done,
   output logic cpu_retry,
   output logic cpu_abort,
   output logic [31:0] cpu_rdata,
   // Target-side user port
   output logic tgt_valid,
   output logic tgt_write,
   output logic [31:0] tgt_addr,
   output logic [31:0] tgt_wdata,
   output logic [3:0] tgt_be_n,
   input wire logic tgt_ready,
   input wire logic [31:0] tgt_rdata,
   input wire logic tgt_stop,
   output logic tgt_xfer,
   // Status queue and AGP initiator ready
   input wire logic st_lp_read,
   input wire port_pkg::port_status_t st_code,
   output logic agp_initiator_ready
);
   localparam int SW = 43;
   localparam logic [3:0] ABORT_CNT = 4'(`ABORT_CYC);

   // Two-flop synchroniser; only stage two is read
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   wire logic [SW-1:0] pins = {port_ad_in, port_cmd_byte_enable_n_in, port_cycle_frame_n_in,
      port_initiator_ready_n_in, port_target_ready_n_in, port_device_select_n_in,
      port_stop_n_in, port_request_n, port_system_error_in_n};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '1;
         sync2_r <= '1;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end
   wire logic [31:0] s_ad = sync2_r[42:11];
   wire logic [3:0] s_cbe_n = sync2_r[10:7];
   wire logic s_frame = !sync2_r[6];
   wire logic s_irdy = !sync2_r[5];
   wire logic s_trdy = !sync2_r[4];
   wire logic s_devsel = !sync2_r[3];
   wire logic s_stop = !sync2_r[2];
   wire logic s_req = !sync2_r[1];
   wire logic s_serr = !sync2_r[0];

   // Arbiter
   arb_if ai ();
   port_arbiter u_arb (
      .mclk(mclk),
      .rst_n(rst_n),
      .a(ai.arb)
   );

   port_pkg::mst_state_t mst_r;
   port_pkg::mst_state_t mst_nxt;
   port_pkg::tgt_state_t tgt_r;
   port_pkg::tgt_state_t tgt_nxt;
   logic frame_d_r;
   logic [31:0] m_addr_r;
   logic [31:0] m_wdata_r;
   logic [3:0] m_be_r;
   logic m_write_r;
   logic devsel_seen_r;
   logic [3:0] cnt_r;
   logic [31:0] rdata_r;
   logic done_r;
   logic retry_r;
   logic abort_r;
   logic [31:0] t_addr_r;
   logic [31:0] t_wdata_r;
   logic [3:0] t_be_r;
   logic t_write_r;
   logic par_r;
   logic par_oe_r;
   logic serr_r;

   // External initiator may not be on the bus while we master it
   wire logic bus_free = mst_r == port_pkg::M_IDLE && tgt_r == port_pkg::T_IDLE &&
                         !s_frame && !s_irdy;
   assign ai.req = s_req;
   assign ai.bus_free = bus_free;
   assign ai.st_lp_read = st_lp_read;
   assign ai.st_code = st_code;
   assign port_grant_n = !ai.gnt;
   assign port_status = ai.st;

   // Master decode
   // A pending request wins, so our master and a fresh grant never start together
   wire logic m_start = mst_r == port_pkg::M_IDLE && cpu_req && pci_style_mode &&
                        bus_free && !ai.gnt && !s_req;
   wire logic m_data = mst_r == port_pkg::M_DATA;
   wire logic m_claimed = s_devsel || devsel_seen_r;
   wire logic m_xfer = m_data && m_claimed && s_trdy;
   wire logic m_stopped = m_data && !m_xfer && s_stop;
   wire logic m_abort = m_data && !m_claimed && cnt_r == ABORT_CNT;
   wire logic m_end = m_xfer || m_stopped || m_abort || (m_data && !pci_style_mode);

   always_comb begin
      mst_nxt = mst_r;
      unique case (mst_r)
         port_pkg::M_IDLE: if (m_start) mst_nxt = port_pkg::M_ADDR;
         port_pkg::M_ADDR: mst_nxt = port_pkg::M_DATA;
         port_pkg::M_DATA: if (m_end) mst_nxt = port_pkg::M_TURN;
         port_pkg::M_TURN: mst_nxt = port_pkg::M_IDLE;
      endcase
   end

   // Target decode: address is taken in the first clock of frame
   wire logic frame_start = s_frame && !frame_d_r;
   wire logic mem_cmd = s_cbe_n == `CMD_MEM_READ || s_cbe_n == `CMD_MEM_WRITE ||
      s_cbe_n == `CMD_MEM_READ_MULT || s_cbe_n == `CMD_MEM_READ_LINE ||
      s_cbe_n == `CMD_MEM_WRITE_INV;
   wire logic in_region = (s_ad & REGION_MASK) == REGION_BASE;
   wire logic t_hit = frame_start && mem_cmd && in_region && pci_style_mode &&
                      mst_r == port_pkg::M_IDLE;
   wire logic t_data = tgt_r == port_pkg::T_DATA;
   wire logic t_trdy = t_data && tgt_ready && !tgt_stop;
   wire logic t_xfer = t_trdy && s_irdy;
   wire logic t_end = t_data && (!pci_style_mode || (!s_frame && (t_xfer || tgt_stop)));

   always_comb begin
      tgt_nxt = tgt_r;
      unique case (tgt_r)
         port_pkg::T_IDLE: if (t_hit) tgt_nxt = port_pkg::T_DATA;
         port_pkg::T_DATA: if (t_end) tgt_nxt = port_pkg::T_TURN;
         port_pkg::T_TURN: tgt_nxt = port_pkg::T_IDLE;
         default: tgt_nxt = port_pkg::T_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mst_r <= port_pkg::M_IDLE;
         tgt_r <= port_pkg::T_IDLE;
         frame_d_r <= 1'b0;
         devsel_seen_r <= 1'b0;
         cnt_r <= 4'h0;
      end else begin
         mst_r <= mst_nxt;
         tgt_r <= tgt_nxt;
         frame_d_r <= s_frame;
         devsel_seen_r <= m_data && m_claimed;
         cnt_r <= m_data ? cnt_r + 4'h1 : 4'h0;
      end
   end

   // Latched request words
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         m_addr_r <= 32'h0;
         m_wdata_r <= 32'h0;
         m_be_r <= 4'hf;
         m_write_r <= 1'b0;
         t_addr_r <= 32'h0;
         t_be_r <= 4'hf;
         t_write_r <= 1'b0;
      end else begin
         if (m_start) begin
            m_addr_r <= cpu_addr;
            m_wdata_r <= cpu_wdata;
            m_be_r <= cpu_be_n;
            m_write_r <= cpu_write;
         end
         if (t_hit) begin
            t_addr_r <= s_ad;
            t_write_r <= s_cbe_n[0];
         end
         if (t_data) t_be_r <= s_cbe_n;
      end
   end

   // Results and captured data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0;
         t_wdata_r <= 32'h0;
         done_r <= 1'b0;
         retry_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         if (m_xfer && !m_write_r) rdata_r <= s_ad;
         if (t_xfer && t_write_r) t_wdata_r <= s_ad;
         done_r <= m_data && m_end;
         retry_r <= m_stopped;
         abort_r <= m_abort;
      end
   end

   // Pin drive: master owns frame/irdy, target owns devsel/trdy/stop
   wire logic m_drive = mst_r == port_pkg::M_ADDR || m_data;
   wire logic m_ad_drive = mst_r == port_pkg::M_ADDR || (m_data && m_write_r);
   wire logic t_ad_drive = t_data && !t_write_r;
   assign port_cycle_frame_n_oe = m_drive;
   assign port_cycle_frame_n_out = mst_r != port_pkg::M_ADDR;
   assign port_initiator_ready_n_oe = m_drive;
   assign port_initiator_ready_n_out = !m_data;
   assign port_cmd_byte_enable_n_oe = m_drive;
   assign port_cmd_byte_enable_n_out = mst_r == port_pkg::M_ADDR ?
      (m_write_r ? `CMD_MEM_WRITE : `CMD_MEM_READ) : m_be_r;
   assign port_ad_oe = m_ad_drive || t_ad_drive;
   assign port_ad_out = mst_r == port_pkg::M_ADDR ? m_addr_r :
                        m_ad_drive ? m_wdata_r : tgt_rdata;
   assign port_device_select_n_oe = t_data;
   assign port_device_select_n_out = !t_data;
   assign port_target_ready_n_oe = t_data;
   assign port_target_ready_n_out = !t_trdy;
   assign port_stop_n_oe = t_data;
   assign port_stop_n_out = !tgt_stop;

   // Even parity over what stood on the bus, one clock late; received parity unused
   wire logic [3:0] bus_cbe = port_cmd_byte_enable_n_oe ? port_cmd_byte_enable_n_out : s_cbe_n;
   wire logic par_nxt = ^{port_ad_out, bus_cbe};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         par_r <= 1'b0;
         par_oe_r <= 1'b0;
         serr_r <= 1'b0;
      end else begin
         par_r <= par_nxt;
         par_oe_r <= port_ad_oe && pci_style_mode;
         serr_r <= s_serr && pci_style_mode && serr_fwd_en;
      end
   end
   assign port_parity_out = par_r;
   assign port_parity_oe = par_oe_r;
   assign pci_system_error_n = !serr_r;

   // User-side outputs
   assign cpu_busy = mst_r != port_pkg::M_IDLE;
   assign cpu_done = done_r;
   assign cpu_retry = retry_r;
   assign cpu_abort = abort_r;
   assign cpu_rdata = rdata_r;
   assign tgt_valid = t_data;
   assign tgt_write = t_write_r;
   assign tgt_addr = t_addr_r;
   assign tgt_wdata = t_wdata_r;
   assign tgt_be_n = t_be_r;
   assign tgt_xfer = t_xfer;
   assign agp_initiator_ready = s_irdy && !pci_style_mode && ai.gnt;

   a_master_frame_addr: assert property (@(posedge mclk) disable iff (!rst_n)
      m_start |=> port_cycle_frame_n_oe && !port_cycle_frame_n_out &&
      port_ad_out == $past(cpu_addr)) else $error("frame or address missing");
   a_stop_ends_xfer: assert property (@(posedge mclk) disable iff (!rst_n)
      m_stopped |=> mst_r == port_pkg::M_TURN ##1 mst_r == port_pkg::M_IDLE && !cpu_busy)
      else $error("stop did not end transfer");
   a_parity_lag: assert property (@(posedge mclk) disable iff (!rst_n)
      port_ad_oe && pci_style_mode |=> port_parity_oe &&
      port_parity_out == ^{$past(port_ad_out), $past(bus_cbe)}) else $error("parity wrong");
   port_system_error_in_n_forward: assert property (@(posedge mclk) disable iff (!rst_n)
      s_serr && pci_style_mode && serr_fwd_en |=> !pci_system_error_n)
      else $error("system error not forwarded");
   port_system_error_in_n_agp_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      !pci_style_mode |=> pci_system_error_n) else $error("system error forwarded in AGP");
   a_agp_no_select: assert property (@(posedge mclk) disable iff (!rst_n)
      !pci_style_mode [*3] |-> !port_device_select_n_oe && !port_parity_oe)
      else $error("select or parity driven in AGP");
   a_only_memory: assert property (@(posedge mclk) disable iff (!rst_n)
      frame_start && !mem_cmd && tgt_r == port_pkg::T_IDLE |=> tgt_r == port_pkg::T_IDLE)
      else $error("non-memory command claimed");
   port_device_select_n_claim: assert property (@(posedge mclk) disable iff (!rst_n)
      t_hit && tgt_r == port_pkg::T_IDLE |=> !port_device_select_n_out &&
      port_device_select_n_oe) else $error("memory hit not claimed");
   a_xfer_pair: assert property (@(posedge mclk) disable iff (!rst_n)
      tgt_xfer |-> port_target_ready_n_oe && !port_target_ready_n_out && tgt_ready &&
      !sync2_r[5]) else $error("transfer without readies");
endmodule : agp_pci_port

/* gfx_partner.sv */
// Graphics controller model that answers as target to the port's master.
// Assumes the bench merges its outputs with pull-ups on the shared control lines.
`timescale 1ns/1ps
module gfx_partner (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Behaviour: 0 prompt, 1 slow, 2 stop, 3 off the bus
   input wire logic [1:0] mode,
   input wire logic rd,
   // Shared pins
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic [31:0] ad,
   output logic devsel_n,
   output logic trdy_n,
   output logic stop_n,
   output logic ad_oe,
   // Write data seen on the bus
   output logic [31:0] wdata
);
   logic act_r;
   logic [3:0] cnt_r;
   wire logic on_w = act_r && mode != 2'h3;
   wire logic [3:0] wait_w = (mode == 2'h1) ? 4'h5 : 4'h1;
   // Inactive select, ready and stop outputs are high, the same level the pull-ups give
   assign devsel_n = !(on_w && cnt_r >= 4'h1);
   assign trdy_n = !(on_w && mode < 2'h2 && cnt_r >= wait_w);
   assign stop_n = !(on_w && mode == 2'h2 && cnt_r >= 4'h1);
   assign ad_oe = on_w && rd && cnt_r >= 4'h1;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         act_r <= 1'b0;
         cnt_r <= 4'h0;
         wdata <= 32'h0;
      end else begin
         if (!frame_n && !act_r) begin
            act_r <= 1'b1;
            cnt_r <= 4'h0;
         end else if (act_r && frame_n && irdy_n && cnt_r >= 4'h2) begin
            act_r <= 1'b0;
         end else if (act_r && cnt_r != 4'hf) begin
            cnt_r <= cnt_r + 4'h1;
         end
         if (on_w && !rd && !irdy_n && !trdy_n) begin
            wdata <= ad;
         end
      end
   end
endmodule : gfx_partner

/* agp_pci_port_handshake_bench.sv */
// Self-checking bench for the graphics-port handshake block.
// Assumes the design files and gfx_partner are compiled first.
`timescale 1ns/1ps
module agp_pci_port_handshake_bench;
   logic mclk = 1'b0, rst_n = 1'b0, mode = 1'b1, sen = 1'b0, req_n = 1'b1, se_n = 1'b1;
   logic creq = 1'b0, cw = 1'b0, trdy = 1'b0, tstp = 1'b0, stlp = 1'b0;
   logic bo = 1'b0, bae = 1'b0, bfr = 1'b1, bir = 1'b1, pae, air, prev_oe = 1'b0, prev_par;
   logic [31:0] ca = 32'h0, cd = 32'h0, trd = 32'h0, bad = 32'h0, prd = 32'h0, xa = 32'h0;
   logic [3:0] cbn = 4'hf, bcb = 4'hf, xc = 4'h0, cb_o, tbe;
   logic [1:0] pm = 2'h3;
   logic [15:0] cyc = 16'h0;
   port_pkg::port_status_t st, stc = 3'h0;
   logic ad_e, cb_e, fr_o, fr_e, ir_o, ir_e, tr_o, tr_e, dv_o, dv_e, sp_o, sp_e, pa_o, pa_e;
   logic gnt_n, pse_n, cbusy, cdone, cretry, cabort, tv, tw, tx, pdv, ptr, psp;
   logic [31:0] ad_o, crd, ta, twd, pwd;
   int n_errors = 0, compares = 0, seed;
   wire logic fr_w = fr_e ? fr_o : (bo ? bfr : 1'b1);
   wire logic ir_w = ir_e ? ir_o : (bo ? bir : 1'b1);
   wire logic tr_w = tr_e ? tr_o : ptr;
   wire logic dv_w = dv_e ? dv_o : pdv;
   wire logic sp_w = sp_e ? sp_o : psp;
   // An undriven data bus keeps changing so a stale value never passes
   wire logic [31:0] ad_w = ad_e ? ad_o : pae ? prd : bae ? bad : {8{cyc[3:0]}};
   wire logic [3:0] cb_w = cb_e ? cb_o : (bo ? bcb : ~cyc[3:0]);
   wire logic pa_w = pa_e ? pa_o : cyc[0];
   always #2 mclk = ~mclk;
   agp_pci_port uut (.mclk(mclk), .rst_n(rst_n), .pci_style_mode(mode), .serr_fwd_en(sen),
      .port_ad_in(ad_w), .port_ad_out(ad_o), .port_ad_oe(ad_e),
      .port_cmd_byte_enable_n_in(cb_w), .port_cmd_byte_enable_n_out(cb_o),
      .port_cmd_byte_enable_n_oe(cb_e), .port_cycle_frame_n_in(fr_w),
      .port_cycle_frame_n_out(fr_o), .port_cycle_frame_n_oe(fr_e),
      .port_initiator_ready_n_in(ir_w), .port_initiator_ready_n_out(ir_o),
      .port_initiator_ready_n_oe(ir_e), .port_target_ready_n_in(tr_w),
      .port_target_ready_n_out(tr_o), .port_target_ready_n_oe(tr_e),
      .port_device_select_n_in(dv_w), .port_device_select_n_out(dv_o),
      .port_device_select_n_oe(dv_e), .port_stop_n_in(sp_w), .port_stop_n_out(sp_o),
      .port_stop_n_oe(sp_e), .port_parity_in(pa_w), .port_parity_out(pa_o),
      .port_parity_oe(pa_e), .port_request_n(req_n), .port_grant_n(gnt_n),
      .port_status(st), .port_system_error_in_n(se_n), .pci_system_error_n(pse_n),
      .cpu_req(creq), .cpu_write(cw), .cpu_addr(ca), .cpu_wdata(cd), .cpu_be_n(cbn),
      .cpu_busy(cbusy), .cpu_done(cdone), .cpu_retry(cretry), .cpu_abort(cabort),
      .cpu_rdata(crd), .tgt_valid(tv), .tgt_write(tw), .tgt_addr(ta), .tgt_wdata(twd),
      .tgt_be_n(tbe), .tgt_ready(trdy), .tgt_rdata(trd), .tgt_stop(tstp), .tgt_xfer(tx),
      .st_lp_read(stlp), .st_code(stc), .agp_initiator_ready(air));
   gfx_partner partner (.mclk(mclk), .rst_n(rst_n), .mode(pm), .rd(!cw), .frame_n(fr_w),
      .irdy_n(ir_w), .ad(ad_w), .devsel_n(pdv), .trdy_n(ptr), .stop_n(psp), .ad_oe(pae),
      .wdata(pwd));
   task automatic chk_bit(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH at %0t: bit got %b exp %b", $time, g, e);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH at %0t: word got %h exp %h", $time, g, e);
      end
   endtask : chk_word
   function automatic logic exp_claim(input logic [3:0] c, input logic [31:0] a);
      return mode && a[31:28] == 4'h0 && (c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf});
   endfunction : exp_claim
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // Parity trails the bus by one clock; master address and data phases
   always @(negedge mclk) begin
      if (rst_n && prev_oe) begin
         chk_bit(pa_e, 1'b1);
         chk_bit(pa_o, prev_par);
      end
      prev_oe = ad_e;
      prev_par = ^{ad_o, cb_w};
      if (rst_n && fr_e && !fr_o) begin
         chk_word(ad_o, xa);
         chk_word({28'h0, cb_o}, {28'h0, xc});
      end
      if (rst_n && fr_e && fr_o) chk_bit(ir_o, 1'b0);
   end
   always @(posedge mclk) begin
      cyc <= cyc + 16'h1;
      if (cyc == 16'h4e20) begin
         n_errors++;
         test_done();
      end
   end
   task automatic arb(input logic lp);
      logic [2:0] c;
      int n;
      c = 3'($random(seed));
      @(posedge mclk);
      stlp <= lp;
      stc <= c;
      req_n <= 1'b0;
      n = 0;
      while (gnt_n !== 1'b0 && n < 10) begin
         @(negedge mclk);
         n++;
      end
      chk_bit(n <= 5, 1'b1);
      chk_word({29'h0, st}, lp ? 32'h0 : {29'h0, c});
      @(posedge mclk);
      bo <= !mode;
      bir <= 1'b0;
      repeat (4) @(negedge mclk);
      chk_bit(air, !mode);
      @(posedge mclk);
      bo <= 1'b0;
      bir <= 1'b1;
      req_n <= 1'b1;
      repeat (6) @(negedge mclk);
      chk_bit(gnt_n, 1'b1);
      $display("test arbiter done");
   endtask : arb
   task automatic mst(input logic w, input logic [1:0] md, input logic [1:0] ex);
      logic [31:0] a;
      logic [31:0] d;
      int n;
      a = $random(seed);
      d = $random(seed);
      @(posedge mclk);
      pm <= md;
      prd <= d;
      cw <= w;
      ca <= a;
      cd <= d;
      cbn <= a[3:0];
      xa <= a;
      xc <= w ? 4'h7 : 4'h6;
      creq <= 1'b1;
      @(posedge mclk);
      creq <= 1'b0;
      n = 0;
      while (cdone !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      chk_bit(cdone, 1'b1);
      chk_bit(cbusy, 1'b1);
      chk_bit(cretry, ex == 2'h1);
      chk_bit(cabort, ex == 2'h2);
      if (ex == 2'h0 && w) chk_word(pwd, d);
      if (ex == 2'h0 && !w) chk_word(crd, d);
      @(posedge mclk);
      pm <= 2'h3;
      @(negedge mclk);
      chk_bit(cbusy, 1'b0);
      $display("test master done");
   endtask : mst
   task automatic tgt(input logic [3:0] c, input logic [31:0] a, input logic stp);
      logic cl;
      logic [31:0] d;
      int n;
      d = $random(seed);
      cl = 1'b0;
      @(posedge mclk);
      trdy <= !stp;
      tstp <= stp;
      trd <= d;
      bo <= 1'b1;
      bae <= 1'b1;
      bfr <= 1'b0;
      bcb <= c;
      bad <= a;
      @(posedge mclk);
      bfr <= 1'b1;
      bir <= 1'b0;
      bae <= c[0];
      bcb <= d[3:0];
      bad <= d;
      n = 0;
      while (n < 12 && !(cl && (tr_w === 1'b0 || sp_w === 1'b0))) begin
         @(negedge mclk);
         if (dv_w === 1'b0) cl = 1'b1;
         n++;
      end
      chk_bit(cl, exp_claim(c, a));
      if (cl) begin
         chk_word(ta, a);
         chk_bit(tv, 1'b1);
         chk_bit(tw, c[0]);
         chk_bit(sp_w, !stp);
         chk_bit(tx, !stp);
         if (!c[0] && !stp) chk_word(ad_w, d);
      end
      @(posedge mclk);
      bo <= 1'b0;
      bae <= 1'b0;
      bir <= 1'b1;
      tstp <= 1'b0;
      repeat (4) @(negedge mclk);
      if (cl) chk_word({28'h0, tbe}, {28'h0, d[3:0]});
      if (cl && c[0] && !stp) chk_word(twd, d);
      @(posedge mclk);
      $display("test target done");
   endtask : tgt
   initial begin
      logic [31:0] r;
      seed = 16189;
      @(negedge mclk);
      chk_bit(gnt_n, 1'b1);
      chk_word({29'h0, st}, 32'h7);
      chk_bit(fr_e | ad_e | dv_e, 1'b0);
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (10) @(negedge mclk);
      chk_bit(gnt_n, 1'b1);
      arb(1'b1);
      arb(1'b0);
      mst(1'b1, 2'h0, 2'h0);
      mst(1'b0, 2'h0, 2'h0);
      mst(1'b0, 2'h1, 2'h0);
      mst(1'b1, 2'h2, 2'h1);
      mst(1'b0, 2'h3, 2'h2);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         mst(r[0], {1'b0, r[1]}, 2'h0);
      end
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         tgt(4'(i), {4'h0, r[27:0]}, 1'b0);
      end
      tgt(4'h6, {4'h1, r[27:0]}, 1'b0);
      tgt(4'h7, {4'h0, r[27:0]}, 1'b1);
      mode <= 1'b0;
      tgt(4'h6, {4'h0, r[27:0]}, 1'b0);
      arb(1'b0);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         mode <= i[0];
         sen <= i[1];
         se_n <= 1'b0;
         repeat (6) @(negedge mclk);
         chk_bit(pse_n, !(i[0] && i[1]));
         @(posedge mclk);
         se_n <= 1'b1;
         repeat (6) @(negedge mclk);
         chk_bit(pse_n, 1'b1);
      end
      $display("test system error done");
      @(posedge mclk);
      req_n <= 1'b0;
      repeat (8) @(negedge mclk);
      chk_bit(gnt_n, 1'b0);
      rst_n = 1'b0;
      #1;
      chk_bit(gnt_n, 1'b1);
      @(posedge mclk);
      rst_n <= 1'b1;
      req_n <= 1'b1;
      $display("test reset done");
      test_done();
   end
endmodule : agp_pci_port_handshake_bench
